/* File: shared/io_regs_map.vh */
// register pointers, field positions, keys and reset values for the i/o register bank
`ifndef IO_REGS_MAP_VH
`define IO_REGS_MAP_VH

// register pointer codes on the word port
`define PTR_HIGH_IMPEDANCE   4'h0
`define PTR_KEYED_RESET      4'h1
`define PTR_CONV_OUT_WRITE   4'h2
`define PTR_CONV_OUT_READ    4'h3
`define PTR_INPUT_RESULT     4'h4
`define PTR_TEMPERATURE      4'h5

// field layout
`define DATA_MSB             11
`define CHAN_MSB             14
`define CHAN_LSB             12
`define TAG_BIT              15
`define RESET_FIELD_MSB      10

// values
`define RESET_KEY            11'h16C
`define READBACK_TAG         1'h1
`define RESULT_TAG           1'h0
`define TEMPERATURE_TAG      4'h8
`define WORD_ZERO            16'h0000
`define DATA_ZERO            12'h000
`define SELECT_ZERO          8'h00
`define KEY_ZERO             11'h000
`define CHAN_ZERO            3'h0

`endif

/* File: src/io_config_and_readback_regs.v */
// register bank for an eight-pin configurable analog/digital i/o device
// What this block does
// - selection bit one forces that pin to high impedance, whatever else is configured.
// - selection bit zero leaves pin function to the pin configuration registers.
// - one read/write selection bit per pin at its index, zero after reset.
// - writing key 101101100 into low eleven reset bits resets everything; upper bits read zero.
// - converter output write loads low twelve data bits into addressed channel register.
// - converter write word upper four bits read zero; data clears on reset.
// - converter readback word has top bit one and binary channel index below it.
// - converter readback low twelve bits return addressed channel input register value.
// - input result word: top bit zero, channel index, twelve-bit conversion value.
// - temperature word: tag 0x8 in upper four bits, twelve-bit value below.
`timescale 1ns/100ps
`default_nettype none
`include "io_regs_map.vh"

module io_config_and_readback_regs #(
  parameter PINS = 8
) (
  input  wire               mclk,
  input  wire               reset_n,
  input  wire               regWrEn,
  input  wire               regRdEn,
  input  wire [3:0]         regAddr,
  input  wire [2:0]         regChan,
  input  wire [15:0]        regWdata,
  input  wire [PINS-1:0]    pinOeCfg,
  input  wire               resultValid,
  input  wire [2:0]         resultChan,
  input  wire [11:0]        resultData,
  input  wire               tempValid,
  input  wire [11:0]        tempData,
  output reg  [15:0]        regRdata,
  output reg                regRdValid,
  output reg  [PINS-1:0]    pinHighZ,
  output reg  [PINS-1:0]    pinOe,
  output reg  [PINS*12-1:0] convOutCodes,
  output reg                softResetPulse
);

  reg  [PINS-1:0] highZSel_r;
  reg  [10:0]     resetField_r;
  reg  [11:0]     convWrite_r;
  reg  [11:0]     convInput_r [0:PINS-1];
  reg  [2:0]      resultChan_r;
  reg  [11:0]     resultData_r;
  reg  [11:0]     tempData_r;
  reg  [15:0]     rdata_nxt;
  wire            keyHit;
  wire            clearAll;
  integer         i;

  // power-on or keyed reset clears every writable register
  assign clearAll = ~reset_n | softResetPulse;
  assign keyHit   = regWrEn && (regAddr == `PTR_KEYED_RESET) &&
                    (regWdata[`RESET_FIELD_MSB:0] == `RESET_KEY);

  // keyed reset strobe, one cycle after the key write
  always @(posedge mclk) begin
    if (~reset_n) begin
      softResetPulse <= 1'b0;
    end else begin
      softResetPulse <= keyHit & ~softResetPulse;
    end
  end

  // writable registers
  always @(posedge mclk) begin
    if (clearAll) begin
      highZSel_r   <= {PINS{1'b0}};
      resetField_r <= `KEY_ZERO;
      convWrite_r  <= `DATA_ZERO;
      for (i = 0; i < PINS; i = i + 1) begin
        convInput_r[i] <= `DATA_ZERO;
      end
    end else if (regWrEn) begin
      case (regAddr)
        `PTR_HIGH_IMPEDANCE: begin
          highZSel_r <= regWdata[PINS-1:0];
        end
        `PTR_KEYED_RESET: begin
          resetField_r <= keyHit ? `KEY_ZERO : regWdata[`RESET_FIELD_MSB:0];
        end
        `PTR_CONV_OUT_WRITE: begin
          convWrite_r          <= regWdata[`DATA_MSB:0];
          convInput_r[regChan] <= regWdata[`DATA_MSB:0];
        end
        default: begin
          convWrite_r <= convWrite_r;
        end
      endcase
    end
  end

  // latest conversion results from the converter side
  always @(posedge mclk) begin
    if (clearAll) begin
      resultChan_r <= `CHAN_ZERO;
      resultData_r <= `DATA_ZERO;
      tempData_r   <= `DATA_ZERO;
    end else begin
      if (resultValid) begin
        resultChan_r <= resultChan;
        resultData_r <= resultData;
      end
      if (tempValid) begin
        tempData_r <= tempData;
      end
    end
  end

  // pin drive: selection bit overrides configured enable
  always @(posedge mclk) begin
    if (clearAll) begin
      pinHighZ <= {PINS{1'b0}};
      pinOe    <= {PINS{1'b0}};
    end else begin
      pinHighZ <= highZSel_r;
      pinOe    <= pinOeCfg & ~highZSel_r;
    end
  end

  // flattened channel input registers toward the converters
  always @(posedge mclk) begin
    if (clearAll) begin
      convOutCodes <= {PINS*(`DATA_MSB+1){1'b0}};
    end else begin
      for (i = 0; i < PINS; i = i + 1) begin
        convOutCodes[i*(`DATA_MSB+1) +: (`DATA_MSB+1)] <= convInput_r[i];
      end
    end
  end

  // readback word select
  always @* begin
    rdata_nxt = `WORD_ZERO;
    case (regAddr)
      `PTR_HIGH_IMPEDANCE: rdata_nxt[PINS-1:0] = highZSel_r;
      `PTR_KEYED_RESET:    rdata_nxt[`RESET_FIELD_MSB:0] = resetField_r;
      `PTR_CONV_OUT_WRITE: rdata_nxt[`DATA_MSB:0] = convWrite_r;
      `PTR_CONV_OUT_READ:  rdata_nxt = {`READBACK_TAG, regChan, convInput_r[regChan]};
      `PTR_INPUT_RESULT:   rdata_nxt = {`RESULT_TAG, resultChan_r, resultData_r};
      `PTR_TEMPERATURE:    rdata_nxt = {`TEMPERATURE_TAG, tempData_r};
      default:             rdata_nxt = `WORD_ZERO;
    endcase
  end

  // registered read answer, one cycle after the request
  always @(posedge mclk) begin
    if (clearAll) begin
      regRdata   <= `WORD_ZERO;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        regRdata <= rdata_nxt;
      end
    end
  end

endmodule // io_config_and_readback_regs

`default_nettype wire

/* File: verif/io_regs_sva.sv */
// port assertions for the i/o register bank
`timescale 1ns/100ps
`default_nettype none
module io_regs_sva #(parameter PINS = 8) (
  input wire            mclk,
  input wire            reset_n,
  input wire            regWrEn,
  input wire            regRdEn,
  input wire [3:0]      regAddr,
  input wire [2:0]      regChan,
  input wire [15:0]     regWdata,
  input wire [PINS-1:0] pinOeCfg,
  input wire [15:0]     regRdata,
  input wire            regRdValid,
  input wire [PINS-1:0] pinHighZ,
  input wire [PINS-1:0] pinOe,
  input wire            softResetPulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // requests in the pulse cycle are lost
  wire live = !softResetPulse;
  a_hiz_blocks_oe: assert property (!(|(pinOe & pinHighZ))) else $error("oe on hiz pin");
  a_oe_follows_cfg: assert property ($past(reset_n) && !$past(softResetPulse) |->
    pinOe == ($past(pinOeCfg) & ~pinHighZ)) else $error("oe");
  a_select_write: assert property (regWrEn && regAddr == 4'h0 && live |-> ##2 pinHighZ == PINS'($past(regWdata, 2))) else $error("sel");
  a_key_pulse: assert property (regWrEn && regAddr == 4'h1 && regWdata[10:0] == 11'h16C && live |=>
    softResetPulse ##1 !softResetPulse) else $error("key");
  a_key_clears: assert property (softResetPulse |=> pinHighZ == 0 && pinOe == 0 && regRdata == 16'h0000) else $error("clr");
  a_read_answer: assert property (live |=> regRdValid == $past(regRdEn)) else $error("rdv");
  a_readback_tag: assert property (regRdEn && regAddr == 4'h3 && live |=> regRdata[15:12] == {1'b1, $past(regChan)}) else $error("rb");
  a_temp_tag: assert property (regRdEn && regAddr == 4'h5 && live |=> regRdata[15:12] == 4'h8) else $error("tmp");
  c_key: cover property (softResetPulse);
  c_hiz: cover property (|pinHighZ);
  c_read: cover property (regRdValid);
endmodule // io_regs_sva
bind io_config_and_readback_regs io_regs_sva #(.PINS(PINS)) i_sva (.*);
`default_nettype wire

/* File: verif/host_model.sv */
// host side driving the register word port
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic        mclk,
  input  wire logic [15:0] regRdata,
  output var  logic        regWrEn,
  output var  logic        regRdEn,
  output var  logic [3:0]  regAddr,
  output var  logic [2:0]  regChan,
  output var  logic [15:0] regWdata
);
  initial {regWrEn, regRdEn, regAddr, regChan, regWdata} = 25'h0;
  // one-cycle write or read, answer taken a cycle later
  task automatic acc(input logic w, input logic [3:0] a, input logic [2:0] c, input logic [15:0] d, output logic [15:0] q);
    @(negedge mclk);
    {regWrEn, regRdEn, regAddr, regChan, regWdata} = {w, !w, a, c, d};
    @(negedge mclk);
    {regWrEn, regRdEn} = 2'h0;
    q = regRdata;
  endtask
endmodule // host_model
`default_nettype wire

/* File: verif/tb_io_config_and_readback_regs.sv */
// self-checking bench for the i/o register bank
`timescale 1ns/100ps
`default_nettype none
module tb_io_config_and_readback_regs;
  logic        mclk = 0, reset_n = 0, resultValid = 0, tempValid = 0, regWrEn, regRdEn, regRdValid, softResetPulse;
  logic [3:0]  regAddr;
  logic [2:0]  regChan, resultChan = 3'h0;
  logic [7:0]  pinOeCfg = 8'hFF, pinHighZ, pinOe;
  logic [11:0] resultData = 12'h000, tempData = 12'h000;
  logic [15:0] regWdata, regRdata, q;
  logic [95:0] convOutCodes;
  int          mismatches = 0, checked = 0, cyc = 0;
  always #2.5 mclk = ~mclk;
  io_config_and_readback_regs i_dut (.*);
  host_model i_host (.*);
  // compare and count
  task automatic chk(input string n, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk) if (++cyc > 2000) begin
    mismatches++;
    conclude;
  end
  task automatic t_hiz;
    i_host.acc(1, 4'h0, 3'h0, 16'hFF05, q);
    i_host.acc(0, 4'h0, 3'h0, 16'h0000, q);
    chk("sel", 16'h0005, q);
    chk("hiz", 16'h0005, {8'h00, pinHighZ});
    chk("oe", 16'h00FA, {8'h00, pinOe});
    $display("hiz done");
  endtask
  task automatic t_conv;
    i_host.acc(1, 4'h2, 3'h7, 16'hFABC, q);
    @(negedge mclk);
    chk("code7", 16'h0ABC, {4'h0, convOutCodes[95:84]});
    i_host.acc(0, 4'h3, 3'h7, 16'h0000, q);
    chk("rb7", 16'hFABC, q);
    i_host.acc(0, 4'h3, 3'h0, 16'h0000, q);
    chk("rb0", 16'h8000, q);
    i_host.acc(0, 4'h2, 3'h0, 16'h0000, q);
    chk("wrword", 16'h0ABC, q);
    $display("conv done");
  endtask
  task automatic t_res;
    @(negedge mclk);
    {resultValid, resultChan, resultData, tempValid, tempData} = {1'b1, 3'h5, 12'h123, 1'b1, 12'h456};
    @(negedge mclk);
    {resultValid, tempValid} = 2'h0;
    i_host.acc(0, 4'h4, 3'h0, 16'h0000, q);
    chk("result", 16'h5123, q);
    chk("rdvalid", 16'h0001, {15'h0000, regRdValid});
    i_host.acc(0, 4'h5, 3'h0, 16'h0000, q);
    chk("temp", 16'h8456, q);
    $display("res done");
  endtask
  task automatic t_key;
    i_host.acc(1, 4'h1, 3'h0, 16'hF16C, q);
    chk("pulse", 16'h0001, {15'h0000, softResetPulse});
    repeat (3) @(posedge mclk);
    chk("codes", 16'h0000, {15'h0000, |convOutCodes});
    for (int a = 0; a < 16; a++) begin
      i_host.acc(0, a[3:0], 3'h0, 16'h0000, q);
      chk("ptr", (a == 3 || a == 5) ? 16'h8000 : 16'h0000, q);
    end
    $display("key done");
  endtask
  initial begin
    repeat (4) @(negedge mclk);
    reset_n = 1;
    t_hiz;
    t_conv;
    t_res;
    t_key;
    conclude;
  end
endmodule // tb_io_config_and_readback_regs
`default_nettype wire
